//--- hw/cts_dev_end.sv
// Functional notes
// R1: Abort flag at bit 0 nullifies packet
// R2: User may abort then end or continue
// R3: Abort sticky for rest of packet
// R4: Abort raised/held only with ready high
// R5: Endpoint reports aborted completion via error report
// R6: Parity bit i is odd parity byte i
// R7: Check 16 bits at 128, 8 at 64
// R8: Parity mismatch: record error, discard packet
// R9: Internal error cleared only by reset
// R10: Parity may be tied zero when disabled
// R11: Request data uses only configured lower width
// R12: Beat moves only when valid and ready
// R13: Last flag marks packet's final beat
// R14: Sideband judged only on completed handshakes
`timescale 1ns/1ps

module cts_dev_end #(
    parameter int unsigned DW = cts_pkg::DEF_DW
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    cts_link_if.dev_end                     lnk,
    input  wire logic                       parity_check_en,
    input  wire logic                       endpoint_mode,
    output logic [DW-1:0]                   tlp_data,
    output logic                            tlp_last,
    output logic                            tlp_nullify,
    output logic                            tlp_discard,
    output logic                            tlp_valid,
    input  wire logic                       tlp_ready,
    output logic                            aer_abort_pulse,
    output logic                            internal_err,
    output logic [cts_pkg::MAX_DW-1:0]      req_payload_out
);
    import cts_pkg::*;

    // ------------------------------------------------------------
    // Local sizes
    // ------------------------------------------------------------
    localparam int unsigned NBYTE = DW / BYTE_W;  // Bytes checked
    localparam int unsigned ENT_W = DW + 3;       // Buffered beat

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cts_pkt_st_t          st_q;
    logic                 abort_q;
    logic                 uie_q;
    logic                 aer_q;
    logic                 acc;
    logic                 abort_in;
    logic                 abort_now;
    logic [PAR_W-1:0]     par_in;
    logic [PAR_W-1:0]     par_bad;
    logic                 perr;
    logic                 push;
    logic                 buf_in_ready;
    logic                 fin;
    logic [ENT_W-1:0]     ent_in;
    logic [ENT_W-1:0]     ent_out;
    logic [MAX_DW-1:0]    req_mask;

    // ------------------------------------------------------------
    // Handshake and sideband decode
    // ------------------------------------------------------------

    // A beat only counts when both sides agree
    assign acc = lnk.completion_beat_valid
               & lnk.completion_accept_ready;           // R12
    assign abort_in = lnk.completion_sideband_in[ABORT_BIT];  // R1
    assign par_in   = lnk.completion_sideband_in[PAR_LSB +: PAR_W];
    assign fin      = lnk.completion_final_beat;        // R13

    // Per-byte odd parity check over configured width
    genvar gi;
    generate
        for (gi = 0; gi < PAR_W; gi++) begin : g_par
            if (gi < NBYTE) begin : g_used
                assign par_bad[gi] = ~(^{lnk.completion_payload_in[
                    gi*BYTE_W +: BYTE_W], par_in[gi]});  // R6 R7
            end else begin : g_unused
                assign par_bad[gi] = 1'b0;               // R7
            end
        end
    endgenerate

    // Mismatch only matters when checking is on
    assign perr = acc & parity_check_en & (|par_bad);   // R8 R10 R14

    // Abort seen now or earlier in this packet
    assign abort_now = abort_in | abort_q;              // R3

    // ------------------------------------------------------------
    // Packet tracking
    // ------------------------------------------------------------

    // Packet state: drop rest after a parity fault
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= PKT_IDLE;
        end else if (acc) begin                         // R14
            case (st_q)
                PKT_IDLE, PKT_FWD: begin
                    if (fin) begin
                        st_q <= PKT_IDLE;
                    end else if (perr) begin
                        st_q <= PKT_DROP;               // R8
                    end else begin
                        st_q <= PKT_FWD;
                    end
                end
                PKT_DROP: begin
                    if (fin) begin
                        st_q <= PKT_IDLE;
                    end
                end
                default: begin
                    st_q <= PKT_IDLE;
                end
            endcase
        end
    end

    // Sticky abort, cleared at packet end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            abort_q <= 1'b0;
        end else if (acc) begin                         // R14
            if (fin) begin
                abort_q <= 1'b0;
            end else if (abort_in) begin
                abort_q <= 1'b1;                        // R2 R3
            end
        end
    end

    // Uncorrectable internal error, reset only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uie_q <= 1'b0;
        end else if (perr) begin
            uie_q <= 1'b1;                              // R8 R9
        end
    end

    // Error report pulse for aborted completion
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aer_q <= 1'b0;
        end else begin
            aer_q <= acc & fin & abort_now & endpoint_mode
                   & (st_q != PKT_DROP) & ~uie_q;       // R5
        end
    end

    // ------------------------------------------------------------
    // Forwarding path
    // ------------------------------------------------------------

    // No beat forwarded while dropping or after a fault
    always_comb begin
        push = acc & (st_q != PKT_DROP) & ~uie_q;       // R9
        ent_in = {perr,                                 // R8
                  abort_now,                            // R1 R3
                  fin | perr,
                  lnk.completion_payload_in};
    end

    cts_pair_buf #(
        .W     (ENT_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .in_data   (ent_in),
        .out_valid (tlp_valid),
        .out_ready (tlp_ready),
        .out_data  (ent_out)
    );

    // Ready offered only while a free slot remains
    assign lnk.completion_accept_ready = buf_in_ready;  // R12

    // Unpack buffered beat
    assign tlp_data    = ent_out[DW-1:0];
    assign tlp_last    = ent_out[DW];
    assign tlp_nullify = ent_out[DW+1];
    assign tlp_discard = ent_out[DW+2];

    assign aer_abort_pulse = aer_q;
    assign internal_err    = uie_q;

    // ------------------------------------------------------------
    // Request data width trim
    // ------------------------------------------------------------

    // Keep only the configured lower lanes
    generate
        if (DW < MAX_DW) begin : g_req_trim
            assign req_mask = {{(MAX_DW-DW){1'b0}},
                               lnk.request_payload_in[DW-1:0]};  // R11
        end else begin : g_req_full
            assign req_mask = lnk.request_payload_in;            // R11
        end
    endgenerate

    // Registered request data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_payload_out <= '0;
        end else begin
            req_payload_out <= req_mask;                // R11
        end
    end

endmodule : cts_dev_end

//--- hw/cts_pkg.sv
package cts_pkg;

    // ------------------------------------------------------------
    // Completion sideband layout
    // ------------------------------------------------------------
    localparam int unsigned SB_W      = 33;   // Whole sideband field
    localparam int unsigned ABORT_BIT = 0;    // Abort flag position
    localparam int unsigned PAR_LSB   = 1;    // First parity bit
    localparam int unsigned PAR_W     = 32;   // Parity bits, one a byte

    // ------------------------------------------------------------
    // Data widths
    // ------------------------------------------------------------
    localparam int unsigned MAX_DW    = 256;  // Widest data bus
    localparam int unsigned DEF_DW    = 256;  // Default configured width
    localparam int unsigned BYTE_W    = 8;    // Bits per parity byte

    // ------------------------------------------------------------
    // Buffer and packet tracking
    // ------------------------------------------------------------
    localparam int unsigned BUF_DEPTH = 2;    // Entries in output buffer

    typedef enum logic [1:0] {
        PKT_IDLE = 2'b00,   // Between packets
        PKT_FWD  = 2'b01,   // Forwarding beats of a packet
        PKT_DROP = 2'b10    // Swallowing rest of a bad packet
    } cts_pkt_st_t;

endpackage : cts_pkg

//--- hw/cts_link_if.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Completion stream between user logic and the device end
// ----------------------------------------------------------------
interface cts_link_if #(
    parameter int unsigned DW = cts_pkg::DEF_DW
);
    logic [DW-1:0]                completion_payload_in;
    logic [cts_pkg::SB_W-1:0]     completion_sideband_in;
    logic                         completion_beat_valid;
    logic                         completion_final_beat;
    logic                         completion_accept_ready;
    logic [cts_pkg::MAX_DW-1:0]   request_payload_in;

    // User application side
    modport user_end (
        output completion_payload_in,
        output completion_sideband_in,
        output completion_beat_valid,
        output completion_final_beat,
        output request_payload_in,
        input  completion_accept_ready
    );

    // Documented device side
    modport dev_end (
        input  completion_payload_in,
        input  completion_sideband_in,
        input  completion_beat_valid,
        input  completion_final_beat,
        input  request_payload_in,
        output completion_accept_ready
    );
endinterface : cts_link_if

//--- hw/cts_pair_buf.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-entry buffer, registered ready and valid
// ----------------------------------------------------------------
module cts_pair_buf #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = cts_pkg::BUF_DEPTH
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data
);
    import cts_pkg::*;

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT  = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          push;
    logic          pop;

    // Handshakes on either side
    assign push = in_valid & in_ready;
    assign pop  = out_valid & out_ready;

    // Occupancy after this cycle
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    // Storage write
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers with wrap
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == LAST_SLOT) ? '0 : wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == LAST_SLOT) ? '0 : rd_ptr_q + PW'(1);
            end
        end
    end

    // Count and registered flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            in_ready  <= (cnt_d != FULL_CNT);
            out_valid <= (cnt_d != '0);
        end
    end

    assign out_data = mem_q[rd_ptr_q];

endmodule : cts_pair_buf

//--- hw/cts_user_end.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// User application end: one-beat holding stage with parity
// ----------------------------------------------------------------
module cts_user_end #(
    parameter int unsigned DW = cts_pkg::DEF_DW
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    cts_link_if.user_end                    lnk,
    input  wire logic                       parity_check_en,
    input  wire logic [DW-1:0]              src_data,
    input  wire logic                       src_abort,
    input  wire logic                       src_last,
    input  wire logic                       src_valid,
    output logic                            src_ready,
    input  wire logic [cts_pkg::MAX_DW-1:0] src_req_data
);
    import cts_pkg::*;

    localparam int unsigned NBYTE = DW / BYTE_W;

    logic [DW-1:0]     data_q;
    logic              last_q;
    logic              abort_q;
    logic              valid_q;
    logic              valid_d;
    logic [PAR_W-1:0]  par_q;
    logic [PAR_W-1:0]  par_d;
    logic              load;
    logic              taken;
    logic [MAX_DW-1:0] req_q;

    assign load  = src_valid & src_ready;
    assign taken = valid_q & lnk.completion_accept_ready;  // R12

    // Odd parity per byte, zero when checking is off
    genvar gi;
    generate
        for (gi = 0; gi < PAR_W; gi++) begin : g_par
            if (gi < NBYTE) begin : g_used
                assign par_d[gi] = parity_check_en
                    & ~(^src_data[gi*BYTE_W +: BYTE_W]);   // R6 R10
            end else begin : g_unused
                assign par_d[gi] = 1'b0;                   // R10
            end
        end
    endgenerate

    // Next valid of the holding stage
    always_comb begin
        valid_d = valid_q;
        if (load) begin
            valid_d = 1'b1;
        end else if (taken) begin
            valid_d = 1'b0;
        end
    end

    // Beat held steady until accepted
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q  <= '0;
            last_q  <= 1'b0;
            abort_q <= 1'b0;
            par_q   <= '0;
        end else if (load) begin
            data_q  <= src_data;
            last_q  <= src_last;                        // R13
            abort_q <= src_abort;                       // R1 R2
            par_q   <= par_d;
        end
    end

    // Valid and upstream ready
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q   <= 1'b0;
            src_ready <= 1'b0;
        end else begin
            valid_q   <= valid_d;                       // R12
            src_ready <= ~valid_d;                      // R4
        end
    end

    // Request data registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;
        end else begin
            req_q <= src_req_data;
        end
    end

    assign lnk.completion_payload_in  = data_q;
    assign lnk.completion_sideband_in = {par_q, abort_q};
    assign lnk.completion_beat_valid  = valid_q;
    assign lnk.completion_final_beat  = last_q;
    assign lnk.request_payload_in     = req_q;

endmodule : cts_user_end

//--- verification/cts_link_monitor.sv
`timescale 1ns/1ps

module cts_link_monitor #(
    parameter int unsigned DW = 256
) (
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire logic [DW-1:0]            completion_payload_in,
    input wire logic [cts_pkg::SB_W-1:0] completion_sideband_in,
    input wire logic                     completion_beat_valid,
    input wire logic                     completion_final_beat,
    input wire logic                     completion_accept_ready,
    input wire logic                     parity_check_en
);
    import cts_pkg::*;

    logic stall;    // Beat offered, not taken
    logic take;     // Beat taken this edge
    logic rel_q;    // Low until first edge after reset
    logic par_bad;  // Some byte fails odd parity

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Handshake shorthands
    assign stall = completion_beat_valid & ~completion_accept_ready;
    assign take  = completion_beat_valid & completion_accept_ready;

    // First edge after reset seen
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_q <= 1'b0;
        end else begin
            rel_q <= 1'b1;
        end
    end

    // Odd parity per data byte
    always_comb begin
        par_bad = 1'b0;
        for (int i = 0; i < DW / BYTE_W; i++) begin
            par_bad = par_bad | ~(^{completion_payload_in[i*BYTE_W +: BYTE_W],
                                    completion_sideband_in[PAR_LSB + i]});
        end
    end

    // ----------------------------------------------------------------
    // Link rules
    // ----------------------------------------------------------------
    AST_HOLD_DATA: assert property (stall |=>
        $stable(completion_payload_in)) else $error("payload moved in stall");
    AST_HOLD_VALID: assert property (stall |=>
        completion_beat_valid) else $error("valid dropped in stall");
    AST_HOLD_LAST: assert property (stall |=>
        $stable(completion_final_beat)) else $error("last moved in stall");
    AST_HOLD_ABORT: assert property (stall |=>
        $stable(completion_sideband_in[ABORT_BIT]))
        else $error("abort moved in stall");
    AST_HOLD_PARITY: assert property (stall |=>
        $stable(completion_sideband_in[PAR_LSB +: PAR_W]))
        else $error("parity moved in stall");
    AST_ODD_PARITY: assert property (
        completion_beat_valid && parity_check_en |-> !par_bad)
        else $error("parity not odd");
    AST_BEAT_GAP: assert property (take |=>
        !completion_beat_valid) else $error("beats back to back");
    AST_READY_UP: assert property (!rel_q |=>
        completion_accept_ready) else $error("ready late after reset");

    // Main scenarios
    cover property (take && completion_sideband_in[ABORT_BIT]);
    cover property (stall);
    cover property (take && !completion_final_beat);
endmodule : cts_link_monitor

//--- verification/tb_completion_tx_sideband_check.sv
`timescale 1ns/1ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module tb_completion_tx_sideband_check;
    import cts_pkg::*;

    logic         core_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         par_en = 1'b1;
    logic         ep_mode = 1'b1;
    logic [255:0] src_data = '0;
    logic         src_abort = 1'b0;
    logic         src_last = 1'b0;
    logic         src_valid = 1'b0;
    logic         src_ready;
    logic [255:0] rq_in = {8{32'ha5a5_0f0f}};
    logic         tlp_ready = 1'b1;
    logic [255:0] tlp_data;
    logic         tlp_last, tlp_null, tlp_disc, tlp_valid, aer, ierr;
    logic [255:0] rq_out;
    logic [127:0] t2_data;
    logic         t2_last, t2_null, t2_disc, t2_valid, ierr2;
    logic [255:0] rq2_out;
    logic [258:0] q1[$];
    logic [130:0] q2[$];
    int           errors = 0;
    int           checks = 0;
    int           aer_n = 0;
    int           full_n = 0;

    cts_link_if lnk_a ();
    cts_link_if #(.DW(128)) lnk_b ();

    cts_user_end cts_user_end_inst (.core_clk(core_clk),
        .rst_n(rst_n), .lnk(lnk_a.user_end), .parity_check_en(par_en),
        .src_data(src_data), .src_abort(src_abort), .src_last(src_last),
        .src_valid(src_valid), .src_ready(src_ready), .src_req_data(rq_in));
    cts_dev_end cts_dev_end_inst (.core_clk(core_clk),
        .rst_n(rst_n), .lnk(lnk_a.dev_end), .parity_check_en(par_en),
        .endpoint_mode(ep_mode), .tlp_data(tlp_data), .tlp_last(tlp_last),
        .tlp_nullify(tlp_null), .tlp_discard(tlp_disc),
        .tlp_valid(tlp_valid), .tlp_ready(tlp_ready),
        .aer_abort_pulse(aer), .internal_err(ierr), .req_payload_out(rq_out));
    cts_dev_end #(.DW(128)) cts_dev_end_inst2 (.core_clk(core_clk),
        .rst_n(rst_n), .lnk(lnk_b.dev_end), .parity_check_en(par_en),
        .endpoint_mode(1'b0), .tlp_data(t2_data), .tlp_last(t2_last),
        .tlp_nullify(t2_null), .tlp_discard(t2_disc), .tlp_valid(t2_valid),
        .tlp_ready(1'b1), .aer_abort_pulse(), .internal_err(ierr2),
        .req_payload_out(rq2_out));
    cts_link_monitor cts_link_monitor_inst (
        .core_clk(core_clk), .rst_n(rst_n),
        .completion_payload_in(lnk_a.completion_payload_in),
        .completion_sideband_in(lnk_a.completion_sideband_in),
        .completion_beat_valid(lnk_a.completion_beat_valid),
        .completion_final_beat(lnk_a.completion_final_beat),
        .completion_accept_ready(lnk_a.completion_accept_ready),
        .parity_check_en(par_en));

    // Clock
    always #50 core_clk = ~core_clk;

    // Collect forwarded beats and events
    always @(posedge core_clk) begin
        if (tlp_valid === 1'b1 && tlp_ready === 1'b1) begin
            q1.push_back({tlp_null, tlp_disc, tlp_last, tlp_data});
        end
        if (t2_valid === 1'b1) begin
            q2.push_back({t2_null, t2_disc, t2_last, t2_data});
        end
        if (aer === 1'b1) begin
            aer_n++;
        end
        if (rst_n && lnk_a.completion_accept_ready === 1'b0) begin
            full_n++;
        end
    end

    function automatic logic [31:0] odd_par(input logic [255:0] d);
        logic [31:0] p;
        for (int i = 0; i < 32; i++) begin
            p[i] = ~^d[i*8 +: 8];
        end
        return p;
    endfunction : odd_par

    task automatic src_beat(input logic [255:0] d, input logic ab, la);
        int n;
        n = 0;
        @(negedge core_clk);
        src_data = d;
        src_abort = ab;
        src_last = la;
        src_valid = 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (src_ready !== 1'b1 && n < 200);
        @(negedge core_clk);
        src_valid = 1'b0;
    endtask : src_beat

    task automatic lnk_beat(input logic [127:0] d, input logic [31:0] pf,
                            input logic la);
        @(negedge core_clk);
        lnk_b.completion_payload_in = d;
        lnk_b.completion_sideband_in = {odd_par({128'h0, d}) ^ pf, 1'b0};
        lnk_b.completion_final_beat = la;
        lnk_b.completion_beat_valid = 1'b1;
        do begin
            @(posedge core_clk);
        end while (lnk_b.completion_accept_ready !== 1'b1);
        @(negedge core_clk);
        lnk_b.completion_beat_valid = 1'b0;
    endtask : lnk_beat

    task automatic drain(input int n1, n2);
        int k;
        k = 0;
        while ((q1.size() < n1 || q2.size() < n2) && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        repeat (4) @(negedge core_clk);
        `CHK(q1.size() + q2.size(), n1 + n2)
    endtask : drain

    task automatic exp1(input logic n, d, l, input logic [255:0] v);
        logic [258:0] got;
        got = (q1.size() > 0) ? q1.pop_front() : 'x;
        `CHK(got, {n, d, l, v})
    endtask : exp1

    task automatic exp2(input logic n, d, l, input logic [127:0] v);
        logic [130:0] got;
        got = (q2.size() > 0) ? q2.pop_front() : 'x;
        `CHK(got, {n, d, l, v})
    endtask : exp2

    task automatic end_sim();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // Watchdog
    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        end_sim();
    end

    // Main sequence
    initial begin
        lnk_b.completion_payload_in = '0;
        lnk_b.completion_sideband_in = '0;
        lnk_b.completion_final_beat = 1'b0;
        lnk_b.completion_beat_valid = 1'b0;
        lnk_b.request_payload_in = '1;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        // Single beat, then abort mid packet, nullified through to the end
        src_beat({8{32'h1111_0001}}, 1'b0, 1'b1);
        src_beat({8{32'h2222_0002}}, 1'b0, 1'b0);
        src_beat({8{32'h3333_0003}}, 1'b1, 1'b0);
        src_beat({8{32'h4444_0004}}, 1'b0, 1'b1);
        drain(4, 0);
        exp1(1'b0, 1'b0, 1'b1, {8{32'h1111_0001}});
        exp1(1'b0, 1'b0, 1'b0, {8{32'h2222_0002}});
        exp1(1'b1, 1'b0, 1'b0, {8{32'h3333_0003}});
        exp1(1'b1, 1'b0, 1'b1, {8{32'h4444_0004}});
        `CHK(aer_n, 1)
        // Abort without endpoint mode
        ep_mode = 1'b0;
        src_beat({8{32'h5555_0005}}, 1'b1, 1'b1);
        drain(1, 0);
        exp1(1'b1, 1'b0, 1'b1, {8{32'h5555_0005}});
        `CHK(aer_n, 1)
        // Stalled link side fills the buffer
        tlp_ready = 1'b0;
        full_n = 0;
        fork
            for (int i = 0; i < 4; i++) begin
                src_beat({8{32'h6000_0000 + 32'(i)}}, 1'b0, i == 3);
            end
            begin
                repeat (30) @(negedge core_clk);
                tlp_ready = 1'b1;
            end
        join
        drain(4, 0);
        for (int i = 0; i < 4; i++) begin
            exp1(1'b0, 1'b0, i == 3, {8{32'h6000_0000 + 32'(i)}});
        end
        `CHK(full_n > 0, 1'b1)
        `CHK(rq_out, rq_in)
        `CHK(ierr, 1'b0)
        // Parity off, inverted parity forwarded
        par_en = 1'b0;
        lnk_beat(128'h0000_0007, 32'hffff_ffff, 1'b1);
        drain(0, 1);
        exp2(1'b0, 1'b0, 1'b1, 128'h0000_0007);
        par_en = 1'b1;
        // Bad parity above the used lanes is ignored
        lnk_beat(128'h0000_0009, 32'h0010_0000, 1'b1);
        drain(0, 1);
        exp2(1'b0, 1'b0, 1'b1, 128'h0000_0009);
        // Bad sideband with no handshake
        lnk_b.completion_sideband_in = 33'h0_0000_0002;
        repeat (4) @(negedge core_clk);
        `CHK(ierr2, 1'b0)
        // Bad parity in first beat of two
        lnk_beat(128'h0000_000a, 32'h0000_0008, 1'b0);
        lnk_beat(128'h0000_000b, 32'h0000_0000, 1'b1);
        drain(0, 1);
        exp2(1'b0, 1'b1, 1'b1, 128'h0000_000a);
        `CHK(ierr2, 1'b1)
        // Good packet after the error is accepted and dropped
        lnk_beat(128'h0000_000c, 32'h0000_0000, 1'b1);
        drain(0, 0);
        `CHK(ierr2, 1'b1)
        `CHK(rq2_out, {128'h0, {128{1'b1}}})
        // Reset clears the error
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK(ierr2, 1'b0)
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        lnk_beat(128'h0000_000d, 32'h0000_0000, 1'b1);
        drain(0, 1);
        exp2(1'b0, 1'b0, 1'b1, 128'h0000_000d);
        end_sim();
    end
endmodule : tb_completion_tx_sideband_check
